// file: swl_lookup_vlan.sv
// Register bank for lookup table status, aging control and VLAN table access.
// Assumes a 10 MHz fabric clock and a register port addressed by register number.
//
// How it works
// - Lookup table initialises after each fabric reset; init-complete reads 0 then 1.
// - Initialisation lasts about 20 microseconds before init-complete sets.
// - Packets received during initialisation are dropped.
// - Entry-creation pending bit is set while the command runs, cleared after.
// - Aging-test bit shortens the aging period from 5 minutes to 50 ms.
// - A write to the VLAN command register launches the described access only while no access is in progress.
// - Command bit 5 picks read when 1, write when 0; resets to 0.
// - Command bit 4 picks the port default table, else the VLAN table.
// - Command bits 3:0 index VLAN 0-15 or port 0-2.
// - Port default data holds VLAN_IDENTIFIER in 11:0 and priority in 14:12.
// - Untagged or null-VLAN_IDENTIFIER packets get the ingress port default VLAN_IDENTIFIER.
// - With VLAN processing off, every packet takes the port default VLAN_IDENTIFIER.
// - Port default priority applies when no other priority source is chosen.
// - Each port default priority is 0 after reset.
// - VLAN entries hold member and tag-strip pairs for ports 2,1,0 in 17:12.
// - VLAN entry bits 11:0 hold the identifier; zero disables the entry.
`include "swl_defs.svh"
`timescale 1ns/1ps
module swl_lookup_vlan
   import swl_pkg::*;
#(
   parameter logic [31:0] AGE_NORM_CYC = 32'(`SWL_AGE_NORM_CYC),
   parameter logic [31:0] AGE_TEST_CYC = 32'(`SWL_AGE_TEST_CYC)
)(
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   input  wire logic [15:0] REG_ADDR,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [31:0] REG_WDATA,
   output      logic [31:0] REG_RDATA,
   input  wire logic        MAKE_START,
   input  wire logic        MAKE_DONE,
   input  wire logic        VLAN_OFF,
   input  wire logic        PKT_VALID,
   input  wire logic [1:0]  PKT_PORT,
   input  wire logic        PKT_TAGGED,
   input  wire logic [11:0] PKT_VID,
   input  wire logic        PKT_PRIO_SEL,
   input  wire logic [2:0]  PKT_PRIO,
   output      logic        PKT_OUT_VALID,
   output      logic        PKT_OUT_DROP,
   output      logic [11:0] PKT_OUT_VID,
   output      logic [2:0]  PKT_OUT_PRIO,
   output      logic        INIT_DONE,
   output      logic        AGE_TEST,
   output      logic        AGE_TICK,
   output      logic        VLAN_BUSY
);
   import swl_pkg::*;

   localparam logic [7:0] INIT_CYC = 8'(`SWL_INIT_CYC);

   swl_top_st_t s;
   swl_top_st_t next_s;
   swl_tbl_if   tbl ();

   logic wr_sts;
   logic wr_cfg;
   logic wr_cmd;
   logic wr_wdat;
   logic cmd_take;

   // Register number match
   function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_no);
      hit = (a == reg_no);
   endfunction

   // Zero-extend an 18-bit table word
   function automatic logic [31:0] ext18(input logic [17:0] d);
      ext18 = {14'h0, d};
   endfunction

   assign wr_sts   = REG_WR && hit(REG_ADDR, `SWL_ADR_ALR_STS);
   assign wr_cfg   = REG_WR && hit(REG_ADDR, `SWL_ADR_ALR_CFG);
   assign wr_cmd   = REG_WR && hit(REG_ADDR, `SWL_ADR_VCMD);
   assign wr_wdat  = REG_WR && hit(REG_ADDR, `SWL_ADR_VWDAT);
   assign cmd_take = wr_cmd && (s.vstate == SWL_IDLE);

   // Table access driven from the registered command
   assign tbl.we      = (s.vstate == SWL_EXEC) && !s.cmd_rnw;
   assign tbl.sel     = s.cmd_sel;
   assign tbl.idx     = s.cmd_idx;
   assign tbl.wdata   = s.wdata;
   assign tbl.lk_port = PKT_PORT;

   always_comb
   begin
      next_s = s;

      // Lookup table initialisation after reset
      if (!s.init_done)
      begin
         if (s.init_cnt >= INIT_CYC - 8'h01)
            next_s.init_done = 1'b1;
         else
            next_s.init_cnt = s.init_cnt + 8'h01;
      end

      // Entry-creation pending; a new start wins over a finish
      if (MAKE_START)
         next_s.make_pend = 1'b1;
      else if (MAKE_DONE)
         next_s.make_pend = 1'b0;

      // Aging configuration
      if (wr_cfg)
         next_s.age_test = REG_WDATA[`SWL_CFG_AGE];

      // Write-data holding register
      if (wr_wdat)
         next_s.wdata = REG_WDATA[`SWL_VT_HI:0];

      // VLAN command sequencer
      case (s.vstate)
         SWL_IDLE:
         begin
            if (cmd_take)
            begin
               next_s.cmd_rnw = REG_WDATA[`SWL_CMD_RNW];
               next_s.cmd_sel = REG_WDATA[`SWL_CMD_SEL];
               next_s.cmd_idx = REG_WDATA[`SWL_CMD_IDX_HI:0];
               next_s.vstate  = SWL_EXEC;
            end
         end
         SWL_EXEC:
         begin
            if (s.cmd_rnw)
               next_s.rdata = tbl.rdata;
            next_s.vstate = SWL_DONE;
         end
         SWL_DONE:
         begin
            next_s.vstate = SWL_IDLE;
         end
         default:
         begin
            next_s.vstate = SWL_IDLE;
         end
      endcase

      // Register read port
      if (REG_RD)
      begin
         if (hit(REG_ADDR, `SWL_ADR_ALR_STS))
            next_s.reg_rdata = {30'h0, s.init_done, s.make_pend};
         else if (hit(REG_ADDR, `SWL_ADR_ALR_CFG))
            next_s.reg_rdata = {31'h0, s.age_test};
         else if (hit(REG_ADDR, `SWL_ADR_VCMD))
            next_s.reg_rdata = {26'h0, s.cmd_rnw, s.cmd_sel, s.cmd_idx};
         else if (hit(REG_ADDR, `SWL_ADR_VWDAT))
            next_s.reg_rdata = ext18(s.wdata);
         else if (hit(REG_ADDR, `SWL_ADR_VRDAT))
            next_s.reg_rdata = ext18(s.rdata);
         else if (hit(REG_ADDR, `SWL_ADR_VSTS))
            next_s.reg_rdata = {31'h0, s.vstate != SWL_IDLE};
         else
            next_s.reg_rdata = 32'h0;
      end

      // Packet default VLAN_IDENTIFIER and priority
      next_s.pkt_valid = PKT_VALID;
      next_s.pkt_drop  = PKT_VALID && !s.init_done;
      if (PKT_VALID)
      begin
         if (VLAN_OFF || !PKT_TAGGED || PKT_VID == 12'h000)
            next_s.pkt_vid = tbl.lk_vid;
         else
            next_s.pkt_vid = PKT_VID;
         if (PKT_PRIO_SEL)
            next_s.pkt_prio = PKT_PRIO;
         else
            next_s.pkt_prio = tbl.lk_prio;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         s <= '0;
         s.vstate <= SWL_IDLE;
      end
      else
         s <= next_s;
   end

   swl_tables u_tables (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .t     (tbl)
   );

   swl_age_timer #(
      .NORM_CYC (AGE_NORM_CYC),
      .TEST_CYC (AGE_TEST_CYC)
   ) u_age (
      .clk     (SYS_CLK),
      .rst_n   (RST_N),
      .run     (s.init_done),
      .shorten (s.age_test),
      .tick    (AGE_TICK)
   );

   assign REG_RDATA     = s.reg_rdata;
   assign PKT_OUT_VALID = s.pkt_valid;
   assign PKT_OUT_DROP  = s.pkt_drop;
   assign PKT_OUT_VID   = s.pkt_vid;
   assign PKT_OUT_PRIO  = s.pkt_prio;
   assign INIT_DONE     = s.init_done;
   assign AGE_TEST      = s.age_test;
   assign VLAN_BUSY     = s.vstate != SWL_IDLE;
endmodule // swl_lookup_vlan

// file: swl_defs.svh
// Constants for the lookup and VLAN table register block.
// Assumes a 10 MHz fabric clock; addresses are register numbers.
`ifndef SWL_DEFS_SVH
`define SWL_DEFS_SVH
`define SWL_ADR_ALR_STS  16'h1808
`define SWL_ADR_ALR_CFG  16'h1809
`define SWL_ADR_VCMD     16'h180B
`define SWL_ADR_VWDAT    16'h180C
`define SWL_ADR_VRDAT    16'h180E
`define SWL_ADR_VSTS     16'h1810
`define SWL_STS_MAKE     0
`define SWL_STS_INIT     1
`define SWL_CFG_AGE      0
`define SWL_VSTS_PEND    0
`define SWL_CMD_RNW      5
`define SWL_CMD_SEL      4
`define SWL_CMD_IDX_HI   3
`define SWL_PV_VID_HI    11
`define SWL_PV_PRI_LO    12
`define SWL_PV_PRI_HI    14
`define SWL_VT_HI        17
`define SWL_NUM_PORTS    2'h3
`define SWL_PVID_RST     12'h001
`define SWL_PPRI_RST     3'h0
`define SWL_CLK_NS       100
`define SWL_INIT_NS      20000
`define SWL_INIT_CYC     (`SWL_INIT_NS / `SWL_CLK_NS)
`define SWL_AGE_NORM_S   300
`define SWL_AGE_TEST_MS  50
`define SWL_AGE_NORM_CYC (64'(`SWL_AGE_NORM_S) * 64'd1000000000 / 64'(`SWL_CLK_NS))
`define SWL_AGE_TEST_CYC (64'(`SWL_AGE_TEST_MS) * 64'd1000000 / 64'(`SWL_CLK_NS))
`endif

// file: swl_pkg.sv
// Types for the lookup and VLAN table register block.
// Assumes swl_defs.svh is compiled alongside.
package swl_pkg;
   typedef enum logic [1:0] {
      SWL_IDLE = 2'h0,
      SWL_EXEC = 2'h1,
      SWL_DONE = 2'h3
   } swl_vstate_t;

   typedef struct packed {
      logic [31:0] cnt;
      logic        mode;
      logic        tick;
   } swl_age_st_t;

   typedef struct packed {
      logic [15:0][17:0] vlan;
      logic [2:0][11:0]  pvid;
      logic [2:0][2:0]   pprio;
   } swl_tbl_st_t;

   typedef struct packed {
      logic [7:0]  init_cnt;
      logic        init_done;
      logic        make_pend;
      logic        age_test;
      logic        cmd_rnw;
      logic        cmd_sel;
      logic [3:0]  cmd_idx;
      logic [17:0] wdata;
      logic [17:0] rdata;
      swl_vstate_t vstate;
      logic [31:0] reg_rdata;
      logic        pkt_valid;
      logic        pkt_drop;
      logic [11:0] pkt_vid;
      logic [2:0]  pkt_prio;
   } swl_top_st_t;
endpackage

// file: swl_tbl_if.sv
// Carrier between the control logic and the table storage.
// Assumes one clock; all signals are combinational requests or replies.
`timescale 1ns/1ps
interface swl_tbl_if;
   logic        we;
   logic        sel;
   logic [3:0]  idx;
   logic [17:0] wdata;
   logic [17:0] rdata;
   logic [1:0]  lk_port;
   logic [11:0] lk_vid;
   logic [2:0]  lk_prio;
   modport ctl (output we, sel, idx, wdata, lk_port, input rdata, lk_vid, lk_prio);
   modport mem (input we, sel, idx, wdata, lk_port, output rdata, lk_vid, lk_prio);
endinterface

// file: swl_age_timer.sv
// Aging tick generator with normal and shortened test periods.
// Assumes run is held low while the lookup table initialises.
`timescale 1ns/1ps
module swl_age_timer
   import swl_pkg::*;
#(
   parameter logic [31:0] NORM_CYC = 32'd3000000000,
   parameter logic [31:0] TEST_CYC = 32'd500000
)(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic run,
   input  wire logic shorten,
   output      logic tick
);
   swl_age_st_t st;
   swl_age_st_t next_st;
   logic [31:0] limit;

   always_comb
   begin
      next_st = st;
      next_st.tick = 1'b0;
      next_st.mode = shorten;
      limit = shorten ? TEST_CYC : NORM_CYC;
      if (!run || (shorten != st.mode))
         next_st.cnt = 32'h0;
      else if (st.cnt >= limit - 32'h1)
      begin
         next_st.cnt = 32'h0;
         next_st.tick = 1'b1;
      end
      else
         next_st.cnt = st.cnt + 32'h1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end

   assign tick = st.tick;
endmodule // swl_age_timer

// file: swl_tables.sv
// VLAN table and per-port default VLAN_IDENTIFIER and priority table in flip-flops.
// Assumes at most one write per cycle through the carrier.
`timescale 1ns/1ps
module swl_tables
   import swl_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   swl_tbl_if.mem    t
);
   swl_tbl_st_t st;
   swl_tbl_st_t next_st;
   logic        port_ok;

   assign port_ok = t.idx[3:2] == 2'h0 && t.idx[1:0] < `SWL_NUM_PORTS;

   always_comb
   begin
      next_st = st;
      if (t.we && t.sel && port_ok)
      begin
         next_st.pvid[t.idx[1:0]] = t.wdata[`SWL_PV_VID_HI:0];
         next_st.pprio[t.idx[1:0]] = t.wdata[`SWL_PV_PRI_HI:`SWL_PV_PRI_LO];
      end
      else if (t.we && !t.sel)
         next_st.vlan[t.idx] = t.wdata;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st.vlan  <= '0;
         st.pvid  <= {3{`SWL_PVID_RST}};
         st.pprio <= {3{`SWL_PPRI_RST}};
      end
      else
         st <= next_st;
   end

   assign t.rdata = !t.sel ? st.vlan[t.idx]
                  : port_ok ? {3'h0, st.pprio[t.idx[1:0]], st.pvid[t.idx[1:0]]}
                  : 18'h0;
   assign t.lk_vid  = (t.lk_port < `SWL_NUM_PORTS) ? st.pvid[t.lk_port] : 12'h0;
   assign t.lk_prio = (t.lk_port < `SWL_NUM_PORTS) ? st.pprio[t.lk_port] : 3'h0;
endmodule // swl_tables

// file: swl_lookup_vlan_props.sv
// Checker on the ports of the lookup and VLAN table register block.
// Assumes it is bound to swl_lookup_vlan with ports matched by name.
`timescale 1ns/1ps
module swl_lookup_vlan_props (
   input wire logic        SYS_CLK,
   input wire logic        RST_N,
   input wire logic [15:0] REG_ADDR,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [31:0] REG_WDATA,
   input wire logic [31:0] REG_RDATA,
   input wire logic        VLAN_OFF,
   input wire logic        PKT_VALID,
   input wire logic        PKT_TAGGED,
   input wire logic [11:0] PKT_VID,
   input wire logic        PKT_PRIO_SEL,
   input wire logic [2:0]  PKT_PRIO,
   input wire logic        PKT_OUT_VALID,
   input wire logic        PKT_OUT_DROP,
   input wire logic [11:0] PKT_OUT_VID,
   input wire logic [2:0]  PKT_OUT_PRIO,
   input wire logic        INIT_DONE,
   input wire logic        AGE_TEST,
   input wire logic        VLAN_BUSY
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_N);
   a_init_sticky: assert property (INIT_DONE |=> INIT_DONE)
      else $error("init flag fell");
   a_drop_early: assert property (PKT_VALID && !INIT_DONE |=> PKT_OUT_VALID && PKT_OUT_DROP)
      else $error("early packet kept");
   a_keep_late: assert property (PKT_VALID && INIT_DONE |=> PKT_OUT_VALID && !PKT_OUT_DROP)
      else $error("late packet dropped");
   a_tag_vid: assert property (PKT_VALID && PKT_TAGGED && PKT_VID != 12'h000 && !VLAN_OFF
      |=> PKT_OUT_VID == $past(PKT_VID))
      else $error("tag vid lost");
   a_prio_src: assert property (PKT_VALID && PKT_PRIO_SEL |=> PKT_OUT_PRIO == $past(PKT_PRIO))
      else $error("chosen prio lost");
   a_busy_launch: assert property (REG_WR && REG_ADDR == 16'h180B && !VLAN_BUSY
      |-> ##[1:2] VLAN_BUSY)
      else $error("command not launched");
   a_busy_ends: assert property ($rose(VLAN_BUSY) |-> ##[1:4] !VLAN_BUSY)
      else $error("busy stuck");
   a_age_bit: assert property (REG_WR && REG_ADDR == 16'h1809 |=> AGE_TEST == $past(REG_WDATA[0]))
      else $error("age bit wrong");
   a_sts_read: assert property (REG_RD && REG_ADDR == 16'h1808 |-> ##2
      REG_RDATA[31:2] == 30'h0 && REG_RDATA[1] == $past(INIT_DONE, 2))
      else $error("status read wrong");
endmodule // swl_lookup_vlan_props
bind swl_lookup_vlan swl_lookup_vlan_props u_swl_lookup_vlan_props (.*);

// file: swl_lookup_vlan_test.sv
// Self-checking bench for the lookup and VLAN table register block.
// Assumes swl_defs.svh, swl_pkg and the design files are compiled first.
`timescale 1ns/1ps
module swl_lookup_vlan_test;
   logic        clk = 0, rst_n = 0, wr = 0, rd = 0, mk_s = 0, mk_d = 0;
   logic        voff = 0, pv = 0, ptag = 0, psel = 0;
   logic [15:0] addr = 16'h0;
   logic [31:0] wdat = 32'h0, rdat, d;
   logic [1:0]  pport = 2'h0;
   logic [11:0] pvid = 12'h0, ovid;
   logic [2:0]  pprio = 3'h0, oprio;
   logic        ov, od, idone, atest, atick, busy;
   int          n_mismatch = 0, checks = 0, n, s, x, v, ok = 0;
   int          vt [16];
   int          dv [3] = '{1, 1, 1};
   int          dp [3] = '{0, 0, 0};
   swl_lookup_vlan #(.AGE_NORM_CYC(32'd40), .AGE_TEST_CYC(32'd10)) u_swl_lookup_vlan (
      .SYS_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
      .REG_WDATA(wdat), .REG_RDATA(rdat), .MAKE_START(mk_s), .MAKE_DONE(mk_d),
      .VLAN_OFF(voff), .PKT_VALID(pv), .PKT_PORT(pport), .PKT_TAGGED(ptag),
      .PKT_VID(pvid), .PKT_PRIO_SEL(psel), .PKT_PRIO(pprio), .PKT_OUT_VALID(ov),
      .PKT_OUT_DROP(od), .PKT_OUT_VID(ovid), .PKT_OUT_PRIO(oprio), .INIT_DONE(idone),
      .AGE_TEST(atest), .AGE_TICK(atick), .VLAN_BUSY(busy));
   always #50 clk = ~clk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [31:0] w);
      @(posedge clk) #10;
      addr = a;
      wdat = w;
      wr = 1;
      @(posedge clk) #10;
      wr = 0;
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
      @(posedge clk) #10;
      addr = a;
      rd = 1;
      @(posedge clk) #10;
      rd = 0;
      @(posedge clk) #1;
      chk(rdat, exp);
   endtask
   task automatic cmd(input logic [31:0] c);
      wr_reg(16'h180B, c);
      n = 0;
      repeat (2) @(posedge clk);
      #1;
      while (busy !== 1'b0 && n < 20)
      begin
         @(posedge clk) #1;
         n++;
      end
      chk(busy, 0);
   endtask
   task automatic pkt(input int p, input logic t, input int i, input logic e, input int r);
      @(posedge clk) #10;
      pport = p[1:0];
      ptag = t;
      pvid = i[11:0];
      psel = e;
      pprio = r[2:0];
      pv = 1;
      @(posedge clk) #10;
      pv = 0;
      chk(ov, 1);
      chk(od, ok == 0);
      chk(ovid, (!voff && t && i != 0) ? i : dv[p]);
      chk(oprio, e ? r : dp[p]);
   endtask
   task automatic age(input int p);
      n = 0;
      while (atick !== 1'b1 && n < 100)
      begin
         @(posedge clk) #1;
         n++;
      end
      n = 0;
      do
      begin
         @(posedge clk) #1;
         n++;
      end while (atick !== 1'b1 && n < 100);
      chk(n, p);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      #400000;
      n_mismatch++;
      test_done;
   end
   initial
   begin
      void'($urandom(32'hB893CC5F));
      repeat (6) @(posedge clk);
      #10 rst_n = 1;
      chk(idone, 0);
      pkt(1, 0, 0, 0, 0);
      repeat (197) @(posedge clk);
      #10 chk(idone, 0);
      @(posedge clk) #10 chk(idone, 1);
      ok = 1;
      rd_chk(16'h1808, 2);
      rd_chk(16'h180B, 0);
      rd_chk(16'h180C, 0);
      rd_chk(16'h1234, 0);
      $display("test reset done");
      @(posedge clk) #10 mk_s = 1;
      @(posedge clk) #10 mk_s = 0;
      rd_chk(16'h1808, 3);
      @(posedge clk) #10 mk_d = 1;
      @(posedge clk) #10 mk_d = 0;
      rd_chk(16'h1808, 2);
      @(posedge clk) #10 mk_s = 1;
      mk_d = 1;
      @(posedge clk) #10 mk_s = 0;
      mk_d = 0;
      rd_chk(16'h1808, 3);
      @(posedge clk) #10 mk_d = 1;
      @(posedge clk) #10 mk_d = 0;
      rd_chk(16'h1808, 2);
      wr_reg(16'h1809, 32'hFFFFFFFF);
      chk(atest, 1);
      rd_chk(16'h1809, 1);
      age(10);
      wr_reg(16'h1809, 0);
      chk(atest, 0);
      age(40);
      $display("test make and aging done");
      for (int i = 0; i < 3; i++)
      begin
         cmd(32'h30 | i);
         rd_chk(16'h180E, 1);
      end
      for (int i = 0; i < 19; i++)
      begin
         s = i > 15;
         x = s ? i - 16 : i;
         d = $urandom;
         if (s)
            d[11:0] = 12'($urandom_range(4094, 1));
         wr_reg(16'h180C, d);
         rd_chk(16'h180C, d & 32'h3FFFF);
         cmd(32'hFFFFFFC0 | (s << 4) | x);
         rd_chk(16'h180B, (s << 4) | x);
         if (s)
         begin
            dv[x] = d[11:0];
            dp[x] = d[14:12];
         end
         else
            vt[x] = d[17:0];
      end
      for (int i = 0; i < 19; i++)
      begin
         s = i > 15;
         x = s ? i - 16 : i;
         cmd(32'h20 | (s << 4) | x);
         rd_chk(16'h180E, s ? (dp[x] << 12) | dv[x] : vt[x]);
         rd_chk(16'h1810, 0);
      end
      wr_reg(16'h180B, 32'h23);
      cmd(32'h25);
      rd_chk(16'h180B, 32'h23);
      rd_chk(16'h180E, vt[3]);
      $display("test tables done");
      for (int p = 0; p < 3; p++)
      begin
         v = $urandom_range(4094, 1);
         pkt(p, 0, v, 0, 0);
         pkt(p, 1, 0, 1, $urandom_range(7, 0));
         pkt(p, 1, v, 0, 0);
         voff = 1;
         pkt(p, 1, v, 1, $urandom_range(7, 0));
         voff = 0;
      end
      $display("test packets done");
      test_done;
   end
endmodule // swl_lookup_vlan_test
